// >>> rtl/cosv_status_view.sv
/*
 * read-only status view of the message handler over axi4-lite
 * assumes handler and interface-register strobes come from aclk logic
 */
// Operation
// - new-data flags of objects 17..32 sit in bits 15:0, upper bits reserved
// - new-data set/cleared by cpu transfers, updated by handler on rx or tx
// - new-data 1 means fresh data written; 0 means nothing since cpu clear
// - interrupt-pending flags of objects 1..16 in bits 15:0 of one register
// - interrupt-pending flags of objects 17..32 in bits 15:0 of second register
// - interrupt-pending set/cleared by cpu transfers, set only by handler after rx/tx
// - lowest numbered pending object is shown in the interrupt identifier value
// - pending flag 1 marks that object as a pending interrupt source
// - valid flags of objects 1..16 in bits 15:0 of one register
// - valid flags of objects 17..32 in bits 15:0 of second register
// - valid flags change only by cpu transfers, never by handler
// - valid 1 makes handler consider object; 0 makes handler ignore it
// - all status registers read-only; contents from handler and transfers
`timescale 1ns/1ns
`include "cosv_defines.svh"
module cosv_status_view (
    // clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // axi4-lite write address
    input  wire logic [31:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    // axi4-lite write data
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    // axi4-lite write response
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // axi4-lite read address
    input  wire logic [31:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    // axi4-lite read data
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // cpu transfers through message interface registers, one bit per object
    input  wire logic [31:0] ifr_fresh_wr,
    input  wire logic [31:0] ifr_fresh_val,
    input  wire logic [31:0] ifr_pend_wr,
    input  wire logic [31:0] ifr_pend_val,
    input  wire logic [31:0] ifr_valid_wr,
    input  wire logic [31:0] ifr_valid_val,
    // handler events, one bit per object
    input  wire logic [31:0] hnd_rx_data,
    input  wire logic [31:0] hnd_tx_done,
    input  wire logic [31:0] hnd_rx_irq,
    input  wire logic [31:0] hnd_tx_irq,
    input  wire logic [31:0] hnd_fresh_clr,
    // flags seen by the handler
    output logic [31:0]      object_active,
    output logic [31:0]      irq_pending_flag,
    output logic [5:0]       irq_ident
);
    logic [31:0] fresh_data_flag;
    logic [31:0] object_valid_flag;
    logic [31:0] pend_raw;
    logic [31:0] fresh_set;
    logic [31:0] pend_set;

    // handler only acts on objects marked valid
    assign fresh_set = hnd_rx_data & object_valid_flag;
    assign pend_set  = (hnd_rx_irq | hnd_tx_irq) & object_valid_flag;

    // fresh data: set on rx data frame, cleared by handler after tx success or clear strobe
    cosv_flag_cell u_fresh (
        .aclk    (aclk),
        .aresetn (aresetn),
        .cpu_wr  (ifr_fresh_wr),
        .cpu_val (ifr_fresh_val),
        .hnd_set (fresh_set),
        .hnd_clr ((hnd_tx_done | hnd_fresh_clr) & object_valid_flag),
        .flags   (fresh_data_flag)
    );

    // interrupt pending per object
    cosv_flag_cell u_pend (
        .aclk    (aclk),
        .aresetn (aresetn),
        .cpu_wr  (ifr_pend_wr),
        .cpu_val (ifr_pend_val),
        .hnd_set (pend_set),
        .hnd_clr ('0),
        .flags   (pend_raw)
    );

    // valid flags: only cpu transfers reach them
    cosv_flag_cell u_valid (
        .aclk    (aclk),
        .aresetn (aresetn),
        .cpu_wr  (ifr_valid_wr),
        .cpu_val (ifr_valid_val),
        .hnd_set ('0),
        .hnd_clr ('0),
        .flags   (object_valid_flag)
    );

    assign object_active    = object_valid_flag;
    assign irq_pending_flag = pend_raw;

    // bus slave state and the interrupt identifier in one struct; the flags stay in the flag cells
    typedef struct packed {
        cosv_pkg::cosv_rd_type rd;
        cosv_pkg::cosv_wr_type wr;
        logic                  aw_got;
        logic                  w_got;
        logic [31:0]           rdata;
        logic [1:0]            rresp;
        logic [1:0]            bresp;
        logic [5:0]            iid;
    } cosv_state_type;
    cosv_state_type st_q;
    cosv_state_type st_d;

    logic [31:0] rd_word;
    logic        rd_hit;
    logic        wr_hit;
    logic [5:0]  iid_next;

    // lowest numbered pending object wins the identifier
    always_comb begin
        iid_next = `COSV_IID_NONE;
        for (int i = `COSV_NUM_OBJ - 1; i >= 0; i--) begin
            if (pend_raw[i]) begin
                iid_next = 6'(i + 1);
            end
        end
    end

    // read decode; upper halves read zero
    always_comb begin
        rd_hit  = 1'b1;
        rd_word = `COSV_RST_FLAGS;
        case (s_axi_araddr)
            `COSV_OFF_ND1: rd_word = {16'h0000, fresh_data_flag[15:0]};
            `COSV_OFF_ND2: rd_word = {16'h0000, fresh_data_flag[31:16]};
            `COSV_OFF_IR1: rd_word = {16'h0000, pend_raw[15:0]};
            `COSV_OFF_IR2: rd_word = {16'h0000, pend_raw[31:16]};
            `COSV_OFF_MV1: rd_word = {16'h0000, object_valid_flag[15:0]};
            `COSV_OFF_MV2: rd_word = {16'h0000, object_valid_flag[31:16]};
            `COSV_OFF_IID: rd_word = {26'h0, st_q.iid};
            default: begin
                rd_hit  = 1'b0;
            end
        endcase
    end

    // write address check; writes never change any status
    always_comb begin
        case (s_axi_awaddr)
            `COSV_OFF_ND1, `COSV_OFF_ND2, `COSV_OFF_IR1, `COSV_OFF_IR2,
            `COSV_OFF_MV1, `COSV_OFF_MV2, `COSV_OFF_IID: wr_hit = 1'b1;
            default: wr_hit = 1'b0;
        endcase
    end

    // handshakes
    assign s_axi_arready = (st_q.rd == cosv_pkg::RD_IDLE);
    assign s_axi_awready = (st_q.wr == cosv_pkg::WR_IDLE) && !st_q.aw_got;
    assign s_axi_wready  = (st_q.wr == cosv_pkg::WR_IDLE) && !st_q.w_got;
    assign s_axi_rvalid  = (st_q.rd == cosv_pkg::RD_RESP);
    assign s_axi_bvalid  = (st_q.wr == cosv_pkg::WR_RESP);
    assign s_axi_rdata   = st_q.rdata;
    assign s_axi_rresp   = st_q.rresp;
    assign s_axi_bresp   = st_q.bresp;
    assign irq_ident     = st_q.iid;

    // next state of the bus slave
    always_comb begin
        st_d     = st_q;
        st_d.iid = iid_next;
        case (st_q.rd)
            cosv_pkg::RD_IDLE: begin
                if (s_axi_arvalid) begin
                    st_d.rd    = cosv_pkg::RD_RESP;
                    st_d.rdata = rd_word;
                    st_d.rresp = rd_hit ? `COSV_RESP_OKAY : `COSV_RESP_SLVERR;
                end
            end
            cosv_pkg::RD_RESP: begin
                if (s_axi_rready) begin
                    st_d.rd = cosv_pkg::RD_IDLE;
                end
            end
            default: st_d.rd = cosv_pkg::RD_IDLE;
        endcase
        case (st_q.wr)
            cosv_pkg::WR_IDLE: begin
                if (s_axi_awvalid && !st_q.aw_got) begin
                    st_d.aw_got = 1'b1;
                    st_d.bresp  = wr_hit ? `COSV_RESP_OKAY : `COSV_RESP_SLVERR;
                end
                if (s_axi_wvalid && !st_q.w_got) begin
                    st_d.w_got = 1'b1;
                end
                if (st_d.aw_got && st_d.w_got) begin
                    st_d.wr     = cosv_pkg::WR_RESP;
                    st_d.aw_got = 1'b0;
                    st_d.w_got  = 1'b0;
                end
            end
            cosv_pkg::WR_RESP: begin
                if (s_axi_bready) begin
                    st_d.wr = cosv_pkg::WR_IDLE;
                end
            end
            default: st_d.wr = cosv_pkg::WR_IDLE;
        endcase
    end

    // state register
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_q.rd     <= cosv_pkg::RD_IDLE;
            st_q.wr     <= cosv_pkg::WR_IDLE;
            st_q.aw_got <= 1'b0;
            st_q.w_got  <= 1'b0;
            st_q.rdata  <= `COSV_RST_FLAGS;
            st_q.rresp  <= `COSV_RESP_OKAY;
            st_q.bresp  <= `COSV_RESP_OKAY;
            st_q.iid    <= `COSV_IID_NONE;
        end else begin
            st_q <= st_d;
        end
    end

    // handler never moves a valid flag
    valid_cpu_only_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (ifr_valid_wr == '0) |=> $stable(object_valid_flag))
        else $error("valid flag changed without cpu transfer");

    // rx data on valid object sets fresh data
    fresh_set_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (hnd_rx_data[16] && object_valid_flag[16]) |=> fresh_data_flag[16])
        else $error("fresh data not set after rx");

    // invalid object is ignored
    invalid_ignored_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (!object_valid_flag[4] && !ifr_pend_wr[4] && !pend_raw[4]) |=> !pend_raw[4])
        else $error("pending set on invalid object");

    // pending set by handler event
    pend_set_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (hnd_tx_irq[19] && object_valid_flag[19]) |=> pend_raw[19])
        else $error("pending not set after tx");

    // identifier follows pending flags one cycle later
    iid_track_a: assert property (@(posedge aclk) disable iff (!aresetn)
        $past(pend_raw) == '0 |-> irq_ident == `COSV_IID_NONE)
        else $error("identifier set with no pending flag");

    // high half read returns reserved zeros
    read_upper_zero_a: assert property (@(posedge aclk) disable iff (!aresetn)
        s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000)
        else $error("reserved read bits not zero");

    // pending read shows the flags
    pend_read_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (s_axi_arvalid && s_axi_arready && s_axi_araddr == `COSV_OFF_IR1)
        |=> s_axi_rdata[15:0] == $past(pend_raw[15:0]))
        else $error("pending low read mismatch");

    // valid upper read shows the flags
    valid_read_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (s_axi_arvalid && s_axi_arready && s_axi_araddr == `COSV_OFF_MV2)
        |=> s_axi_rdata[15:0] == $past(object_valid_flag[31:16]))
        else $error("valid high read mismatch");

    // bus writes leave the valid flags alone
    write_ignored_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (s_axi_wvalid && ifr_valid_wr == '0) |=> $stable(object_valid_flag))
        else $error("bus write altered valid flags");

    // tx success on a valid object clears fresh data
    fresh_clear_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (hnd_tx_done[16] && object_valid_flag[16] && !hnd_rx_data[16] && !ifr_fresh_wr[16])
        |=> !fresh_data_flag[16])
        else $error("fresh data not cleared after tx");

    // handler clear strobe on a valid object clears fresh data
    fresh_strobe_clr_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (hnd_fresh_clr[17] && object_valid_flag[17] && !hnd_rx_data[17] && !ifr_fresh_wr[17])
        |=> !fresh_data_flag[17])
        else $error("fresh data not cleared by strobe");

    // cpu transfer loads fresh data unless a handler set collides
    fresh_cpu_load_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (ifr_fresh_wr[31] && !(hnd_rx_data[31] && object_valid_flag[31]))
        |=> fresh_data_flag[31] == $past(ifr_fresh_val[31]))
        else $error("fresh data cpu load lost");

    // cpu transfer loads pending unless a handler set collides
    pend_cpu_load_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (ifr_pend_wr[2] && !((hnd_rx_irq[2] || hnd_tx_irq[2]) && object_valid_flag[2]))
        |=> pend_raw[2] == $past(ifr_pend_val[2]))
        else $error("pending cpu load lost");

    // cpu transfer loads the valid flag
    valid_cpu_load_a: assert property (@(posedge aclk) disable iff (!aresetn)
        ifr_valid_wr[4] |=> object_valid_flag[4] == $past(ifr_valid_val[4]))
        else $error("valid cpu load lost");

    // lowest pending object names the identifier
    iid_lowest_a: assert property (@(posedge aclk) disable iff (!aresetn)
        $past(pend_raw[2:0]) == 3'h4 |-> irq_ident == 6'h03)
        else $error("identifier not lowest pending object");

    // any pending object shows up in the identifier
    iid_source_a: assert property (@(posedge aclk) disable iff (!aresetn)
        $past(pend_raw) != '0 |-> irq_ident != `COSV_IID_NONE)
        else $error("pending flag without identifier");

    // fresh data upper read shows the flags
    fresh_read_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (s_axi_arvalid && s_axi_arready && s_axi_araddr == `COSV_OFF_ND2)
        |=> s_axi_rdata[15:0] == $past(fresh_data_flag[31:16]))
        else $error("fresh data high read mismatch");

    // pending upper read shows the flags
    pend_hi_read_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (s_axi_arvalid && s_axi_arready && s_axi_araddr == `COSV_OFF_IR2)
        |=> s_axi_rdata[15:0] == $past(pend_raw[31:16]))
        else $error("pending high read mismatch");

    // valid lower read shows the flags
    valid_lo_read_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (s_axi_arvalid && s_axi_arready && s_axi_araddr == `COSV_OFF_MV1)
        |=> s_axi_rdata[15:0] == $past(object_valid_flag[15:0]))
        else $error("valid low read mismatch");

    // read answer follows the address one cycle later
    read_answer_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (s_axi_arvalid && s_axi_arready) |=> s_axi_rvalid)
        else $error("read answer missing");

    // no new read address while an answer stands
    read_refused_a: assert property (@(posedge aclk) disable iff (!aresetn)
        s_axi_rvalid |-> !s_axi_arready)
        else $error("read address taken during answer");

    // write to a status register is accepted and ignored
    write_okay_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (s_axi_awvalid && s_axi_awready && s_axi_awaddr == `COSV_OFF_ND2)
        |=> s_axi_bresp == `COSV_RESP_OKAY)
        else $error("status write not answered okay");

    // unmapped read refused with zero data
    slverr_read_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (s_axi_arvalid && s_axi_arready && !rd_hit)
        |=> (s_axi_rresp == `COSV_RESP_SLVERR && s_axi_rdata == '0))
        else $error("unmapped read not refused");
endmodule : cosv_status_view

// >>> include/cosv_defines.svh
/*
 * register offsets, field positions and reset values of the object status view
 * assumes inclusion by bare name from design files
 */
`ifndef COSV_DEFINES_SVH
`define COSV_DEFINES_SVH

`define COSV_NUM_OBJ        32
`define COSV_HALF_W         16
`define COSV_ADDR_W         32
`define COSV_OFF_ND2        32'h40050124
`define COSV_OFF_IR1        32'h40050140
`define COSV_OFF_IR2        32'h40050144
`define COSV_OFF_MV1        32'h40050160
`define COSV_OFF_MV2        32'h40050164
`define COSV_OFF_ND1        32'h40050120
`define COSV_OFF_IID        32'h40050170
`define COSV_RST_FLAGS      32'h00000000
`define COSV_RESP_OKAY      2'h0
`define COSV_RESP_SLVERR    2'h2
`define COSV_IID_NONE       6'h00

`endif

// >>> include/cosv_pkg.sv
/*
 * types of the object status view
 * assumes cosv_defines.svh is on the include path
 */
`include "cosv_defines.svh"
package cosv_pkg;
    // read channel states
    typedef enum logic [0:0] {
        RD_IDLE = 1'b0,
        RD_RESP = 1'b1
    } cosv_rd_type;
    // write channel states
    typedef enum logic [1:0] {
        WR_IDLE = 2'b00,
        WR_RESP = 2'b01
    } cosv_wr_type;
endpackage : cosv_pkg

// >>> rtl/cosv_flag_cell.sv
/*
 * one set of 32 per-object flags with prioritised update sources
 * assumes all inputs are synchronous to aclk
 */
`timescale 1ns/1ns
`include "cosv_defines.svh"
module cosv_flag_cell (
    // clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // cpu transfer through the interface registers
    input  wire logic [31:0] cpu_wr,
    input  wire logic [31:0] cpu_val,
    // handler updates
    input  wire logic [31:0] hnd_set,
    input  wire logic [31:0] hnd_clr,
    // current flags
    output logic      [31:0] flags
);
    typedef struct packed {
        logic [31:0] f;
    } cosv_cell_type;
    cosv_cell_type state_q;
    cosv_cell_type state_d;

    // per-object next value: handler set wins over any clear
    always_comb begin
        state_d = state_q;
        for (int i = 0; i < `COSV_NUM_OBJ; i++) begin
            if (hnd_set[i]) begin
                state_d.f[i] = 1'b1;
            end else if (cpu_wr[i]) begin
                state_d.f[i] = cpu_val[i];
            end else if (hnd_clr[i]) begin
                state_d.f[i] = 1'b0;
            end
        end
    end

    // state register
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_q.f <= `COSV_RST_FLAGS;
        end else begin
            state_q <= state_d;
        end
    end

    assign flags = state_q.f;
endmodule : cosv_flag_cell

// >>> tb/tb_can_object_status_view.sv
/*
 * self-checking bench of the object status view: axi reads, flag events, ignored writes
 * assumes cosv_defines.svh on the include path and a 20 MHz aclk
 */
`timescale 1ns/1ns
`include "cosv_defines.svh"
module tb_can_object_status_view;
    logic        aclk = 0, aresetn = 0;
    logic [31:0] s_axi_awaddr = 0, s_axi_wdata = 0, s_axi_araddr = 0, s_axi_rdata;
    logic [3:0]  s_axi_wstrb = 4'hF;
    logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
    logic        s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic        s_axi_rvalid;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic [31:0] ifr_fresh_wr = 0, ifr_fresh_val = 0, ifr_pend_wr = 0, ifr_pend_val = 0;
    logic [31:0] ifr_valid_wr = 0, ifr_valid_val = 0, hnd_rx_data = 0, hnd_tx_done = 0;
    logic [31:0] hnd_rx_irq = 0, hnd_tx_irq = 0, hnd_fresh_clr = 0;
    logic [31:0] object_active, irq_pending_flag;
    logic [5:0]  irq_ident;
    int          fails = 0, total_checks = 0, cycles = 0;

    cosv_status_view dut_u (
        .aclk             (aclk),             .aresetn          (aresetn),
        .s_axi_awaddr     (s_axi_awaddr),     .s_axi_awvalid    (s_axi_awvalid),
        .s_axi_awready    (s_axi_awready),    .s_axi_wdata      (s_axi_wdata),
        .s_axi_wstrb      (s_axi_wstrb),      .s_axi_wvalid     (s_axi_wvalid),
        .s_axi_wready     (s_axi_wready),     .s_axi_bresp      (s_axi_bresp),
        .s_axi_bvalid     (s_axi_bvalid),     .s_axi_bready     (s_axi_bready),
        .s_axi_araddr     (s_axi_araddr),     .s_axi_arvalid    (s_axi_arvalid),
        .s_axi_arready    (s_axi_arready),    .s_axi_rdata      (s_axi_rdata),
        .s_axi_rresp      (s_axi_rresp),      .s_axi_rvalid     (s_axi_rvalid),
        .s_axi_rready     (s_axi_rready),     .ifr_fresh_wr     (ifr_fresh_wr),
        .ifr_fresh_val    (ifr_fresh_val),    .ifr_pend_wr      (ifr_pend_wr),
        .ifr_pend_val     (ifr_pend_val),     .ifr_valid_wr     (ifr_valid_wr),
        .ifr_valid_val    (ifr_valid_val),    .hnd_rx_data      (hnd_rx_data),
        .hnd_tx_done      (hnd_tx_done),      .hnd_rx_irq       (hnd_rx_irq),
        .hnd_tx_irq       (hnd_tx_irq),       .hnd_fresh_clr    (hnd_fresh_clr),
        .object_active    (object_active),    .irq_pending_flag (irq_pending_flag),
        .irq_ident        (irq_ident)
    );

    // clock and hang guard
    always #25 aclk = ~aclk;
    always @(posedge aclk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            fails = fails + 1;
            final_report();
        end
    end

    task automatic final_report();
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : final_report

    task automatic chk_data(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            fails++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk_data

    task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
        total_checks++;
        if (got !== exp) begin
            fails++;
            $display("BAD t=%0t resp got=%h exp=%h", $time, got, exp);
        end
    endtask : chk_resp

    // write: offer address and data together, release each when taken
    task automatic axi_write(input logic [31:0] a, input logic [31:0] d, output logic [1:0] r);
        logic ta, tw, tb, done;
        done = 0;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1;
        s_axi_wvalid <= 1;
        s_axi_bready <= 1;
        while (!done) begin
            @(negedge aclk);
            ta = s_axi_awvalid & s_axi_awready;
            tw = s_axi_wvalid & s_axi_wready;
            tb = s_axi_bvalid & s_axi_bready;
            r = s_axi_bresp;
            @(posedge aclk);
            if (ta) s_axi_awvalid <= 0;
            if (tw) s_axi_wvalid <= 0;
            if (tb) begin
                s_axi_bready <= 0;
                done = 1;
            end
        end
    endtask : axi_write

    task automatic axi_read(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
        logic ta, tr, done;
        done = 0;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1;
        s_axi_rready <= 1;
        while (!done) begin
            @(negedge aclk);
            ta = s_axi_arvalid & s_axi_arready;
            tr = s_axi_rvalid & s_axi_rready;
            d = s_axi_rdata;
            r = s_axi_rresp;
            @(posedge aclk);
            if (ta) s_axi_arvalid <= 0;
            if (tr) begin
                s_axi_rready <= 0;
                done = 1;
            end
        end
    endtask : axi_read

    task automatic rd_chk(input logic [31:0] a, input logic [31:0] exp);
        logic [31:0] d;
        logic [1:0]  r;
        axi_read(a, d, r);
        chk_data(d, exp);
        chk_resp(r, `COSV_RESP_OKAY);
    endtask : rd_chk

    // one-cycle event: 0 fresh,1 pend,2 valid cpu loads; 3 rx,4 tx done,5 rx irq,6 tx irq,7 clr
    task automatic ev(input int k, input logic [31:0] m, input logic [31:0] v);
        @(posedge aclk);
        case (k)
            0: begin ifr_fresh_wr <= m; ifr_fresh_val <= v; end
            1: begin ifr_pend_wr <= m; ifr_pend_val <= v; end
            2: begin ifr_valid_wr <= m; ifr_valid_val <= v; end
            3: hnd_rx_data <= m;
            4: hnd_tx_done <= m;
            5: hnd_rx_irq <= m;
            6: hnd_tx_irq <= m;
            default: hnd_fresh_clr <= m;
        endcase
        @(posedge aclk);
        {ifr_fresh_wr, ifr_pend_wr, ifr_valid_wr, hnd_rx_data} <= '0;
        {hnd_tx_done, hnd_rx_irq, hnd_tx_irq, hnd_fresh_clr} <= '0;
        repeat (2) @(posedge aclk);
    endtask : ev

    task automatic s_reset();
        rd_chk(`COSV_OFF_ND2, `COSV_RST_FLAGS);
        rd_chk(`COSV_OFF_IR1, `COSV_RST_FLAGS);
        rd_chk(`COSV_OFF_IR2, `COSV_RST_FLAGS);
        rd_chk(`COSV_OFF_MV1, `COSV_RST_FLAGS);
        rd_chk(`COSV_OFF_MV2, `COSV_RST_FLAGS);
    endtask : s_reset

    // every object valid except object 5
    task automatic s_valid();
        ev(2, 32'hFFFFFFFF, 32'hFFFFFFEF);
        rd_chk(`COSV_OFF_MV1, 32'h0000FFEF);
        rd_chk(`COSV_OFF_MV2, 32'h0000FFFF);
        chk_data(object_active, 32'hFFFFFFEF);
    endtask : s_valid

    task automatic s_fresh();
        ev(3, 32'h80010000, 0);
        rd_chk(`COSV_OFF_ND2, 32'h00008001);
        rd_chk(`COSV_OFF_ND1, 32'h00000000);
        ev(4, 32'h00010000, 0);
        rd_chk(`COSV_OFF_ND2, 32'h00008000);
        ev(0, 32'h80000000, 0);
        rd_chk(`COSV_OFF_ND2, 32'h00000000);
        ev(3, 32'h00020000, 0);
        rd_chk(`COSV_OFF_ND2, 32'h00000002);
        ev(7, 32'h00020000, 0);
        rd_chk(`COSV_OFF_ND2, 32'h00000000);
        ev(0, 32'h00020000, 32'hFFFFFFFF);
        rd_chk(`COSV_OFF_ND2, 32'h00000002);
        rd_chk(`COSV_OFF_MV2, 32'h0000FFFF);
    endtask : s_fresh

    task automatic s_pend();
        ev(5, 32'h00000004, 0);
        ev(6, 32'h00080000, 0);
        rd_chk(`COSV_OFF_IR1, 32'h00000004);
        rd_chk(`COSV_OFF_IR2, 32'h00000008);
        chk_data(irq_pending_flag, 32'h00080004);
        chk_data({26'h0, irq_ident}, 32'h00000003);
        rd_chk(`COSV_OFF_IID, 32'h00000003);
        ev(1, 32'h00000004, 0);
        rd_chk(`COSV_OFF_IR1, 32'h00000000);
        chk_data({26'h0, irq_ident}, 32'h00000014);
        ev(5, 32'h00000010, 0);
        rd_chk(`COSV_OFF_IR1, 32'h00000000);
        ev(1, 32'h00080000, 0);
        chk_data({26'h0, irq_ident}, 32'h00000000);
        rd_chk(`COSV_OFF_MV1, 32'h0000FFEF);
    endtask : s_pend

    // bus writes leave the flags alone; unmapped reads are refused
    task automatic s_ro();
        logic [31:0] d;
        logic [1:0]  r;
        axi_write(`COSV_OFF_ND2, 32'hFFFFFFFF, r);
        chk_resp(r, `COSV_RESP_OKAY);
        axi_write(`COSV_OFF_MV1, 32'h00000000, r);
        chk_resp(r, `COSV_RESP_OKAY);
        axi_write(`COSV_OFF_IR2, 32'hFFFFFFFF, r);
        chk_resp(r, `COSV_RESP_OKAY);
        rd_chk(`COSV_OFF_ND2, 32'h00000002);
        rd_chk(`COSV_OFF_MV1, 32'h0000FFEF);
        rd_chk(`COSV_OFF_IR2, 32'h00000000);
        axi_read(32'h40050200, d, r);
        chk_resp(r, `COSV_RESP_SLVERR);
        chk_data(d, 32'h00000000);
    endtask : s_ro

    // main sequence
    initial begin
        repeat (8) @(posedge aclk);
        aresetn <= 1;
        s_reset();
        s_valid();
        s_fresh();
        s_pend();
        s_ro();
        final_report();
    end
endmodule : tb_can_object_status_view
